// File: fp_mode_trap_control.sv
// Mode control, trap decision, sticky flags and short vector issue.
// Assumes the host holds op_valid until op_accept and datapaths on core_clk.
`timescale 1ns/10ps
module fp_mode_trap_control
  import fp_mode_trap_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic op_valid,
  input wire op_class_t op_class,
  input wire logic op_double,
  input wire logic [REG_W-1:0] op_dest,
  input wire logic [REG_W-1:0] op_src_n,
  input wire logic [REG_W-1:0] op_src_m,
  input wire logic [CSR_W-1:0] op_wdata,
  input wire logic op_any_subnormal,
  input wire logic op_any_nan,
  input wire logic op_any_snan,
  input wire logic op_may_underflow,
  input wire logic op_may_overflow,
  input wire logic op_may_invalid,
  input wire logic op_may_not_fit,
  input wire logic res_valid,
  input wire logic res_tiny,
  input wire logic [EXC_W-1:0] res_flags,
  input wire logic cmp_valid,
  input wire logic [3:0] cmp_nzcv,
  input wire logic [NUM_REGS-1:0] wb_clr_mask,
  output logic op_accept,
  output logic trap_req,
  output logic [CSR_W-1:0] ctl_rdata,
  output logic ctl_rvalid,
  output logic [3:0] host_nzcv,
  output logic host_nzcv_valid,
  output logic elem_valid,
  output logic [REG_W-1:0] elem_dest,
  output logic [REG_W-1:0] elem_src_n,
  output logic [REG_W-1:0] elem_src_m,
  output logic elem_double,
  output op_class_t elem_class,
  output logic elem_last,
  output logic elem_write_en,
  output logic elem_flush_inputs,
  output logic elem_flush_result,
  output logic elem_default_nan,
  output logic elem_keep_nan_frac,
  output logic [CSR_W-1:0] fp_status_control,
  output logic runfast
);

  typedef struct packed {
    seq_state_t state;
    logic [CSR_W-1:0] csr;
    logic runfast;
    logic accept;
    logic trap;
    logic [CSR_W-1:0] rdata;
    logic rvalid;
    logic [3:0] host_nzcv;
    logic host_valid;
    logic e_valid;
    logic [REG_W-1:0] e_dest;
    logic [REG_W-1:0] e_n;
    logic [REG_W-1:0] e_m;
    logic e_double;
    op_class_t e_class;
    logic e_last;
    logic e_wen;
    logic e_flush_in;
    logic e_flush_res;
    logic e_dnan;
    logic e_keep;
    logic [3:0] cnt;
    logic [BANK_IDX_W-1:0] off;
    logic [2:0] units;
    logic scal_m;
    logic [REG_W-1:0] base_d;
    logic [REG_W-1:0] base_n;
    logic [REG_W-1:0] base_m;
  } st_t;

  st_t st_q;
  st_t st_d;
  logic [1:0] rst_sync_q;
  logic rst_n;
  logic [NUM_REGS-1:0] busy;
  logic [NUM_REGS-1:0] set_mask;
  logic [NUM_REGS-1:0] mask_d;
  logic [NUM_REGS-1:0] mask_src;
  logic [CSR_W-1:0] hw_set;
  logic [3:0] n_ops_raw;
  logic [3:0] n_ops;
  logic [2:0] step_single;
  logic [2:0] units;
  logic m_scalar;
  logic hazard;
  logic ctl_op;
  logic take;
  logic trap_cond;
  logic sw_wr;
  logic flush_mode;
  logic dnan_mode;

  function automatic logic is_arith(input op_class_t c);
    return (c == OP_ARITH) || (c == OP_CONV_INT);
  endfunction : is_arith

  function automatic logic writes_reg(input op_class_t c);
    return is_arith(c) || (c == OP_ABS) || (c == OP_NEG) || (c == OP_COPY);
  endfunction : writes_reg

  // Registers touched by a vector; addressing wraps inside the bank
  function automatic logic [NUM_REGS-1:0] vec_mask(input logic [REG_W-1:0] base,
      input logic [3:0] cnt, input logic [2:0] step, input logic dbl);
    logic [NUM_REGS-1:0] m;
    logic [BANK_IDX_W-1:0] idx;
    m = '0;
    idx = base[BANK_IDX_W-1:0];
    for (int i = 0; i < MAX_SINGLE_OPS; i++) begin
      if (4'(i) < cnt) begin
        m[{base[REG_W-1:BANK_IDX_W], idx}] = 1'h1;
        if (dbl) begin
          m[{base[REG_W-1:BANK_IDX_W], BANK_IDX_W'(idx + UNIT_ONE)}] = 1'h1;
        end
        idx = BANK_IDX_W'(idx + step);
      end
    end
    return m;
  endfunction : vec_mask

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_q[1];

  reg_busy_table #(
    .NREG(NUM_REGS)
  ) u_busy (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .set_mask(set_mask),
    .clr_mask(wb_clr_mask),
    .busy_q(busy)
  );

  assign flush_mode = st_q.csr[BIT_FLUSH];
  assign dnan_mode = st_q.csr[BIT_DEF_NAN];

  always_comb begin
    n_ops_raw = {1'h0, st_q.csr[COUNT_HI:COUNT_LO]} + ONE_OP;
    if (op_dest[REG_W-1:BANK_IDX_W] == SCALAR_BANK) begin
      n_ops = ONE_OP;
    end else if (op_double && (n_ops_raw > MAX_DOUBLE_OPS)) begin
      n_ops = MAX_DOUBLE_OPS;
    end else begin
      n_ops = n_ops_raw;
    end
    step_single = (st_q.csr[STEP_HI:STEP_LO] == STEP_TWO) ? UNIT_TWO : UNIT_ONE;
    units = op_double ? 3'(step_single << 1) : step_single;
    m_scalar = (op_src_m[REG_W-1:BANK_IDX_W] == SCALAR_BANK);
    mask_d = writes_reg(op_class) ? vec_mask(op_dest, n_ops, units, op_double) : '0;
    mask_src = vec_mask(op_src_n, n_ops, units, op_double)
             | vec_mask(op_src_m, m_scalar ? ONE_OP : n_ops, units, op_double);
  end

  assign hazard = |((mask_src | mask_d) & busy);
  assign ctl_op = (op_class == OP_MOVE_TO_CTL) || (op_class == OP_MOVE_FROM_CTL)
               || (op_class == OP_FLAG_XFER);
  // Control moves serialise behind every op with a register write still pending
  assign take = (st_q.state == ST_IDLE) && op_valid && !hazard && (!ctl_op || (busy == '0));

  assign trap_cond = (is_arith(op_class)
      && ((!flush_mode && op_any_subnormal) || (!dnan_mode && op_any_nan)
      || (!flush_mode && op_may_underflow)
      || st_q.csr[BIT_INEXACT_EN] || (st_q.csr[BIT_OVFL_EN] && op_may_overflow)
      || (st_q.csr[BIT_INVALID_EN] && (op_may_invalid || op_any_snan))))
      || ((op_class == OP_CONV_INT) && st_q.csr[BIT_INVALID_EN] && op_may_not_fit);

  always_comb begin
    st_d = st_q;
    st_d.accept = 1'h0;
    st_d.trap = 1'h0;
    st_d.rvalid = 1'h0;
    st_d.host_valid = 1'h0;
    st_d.e_valid = 1'h0;
    set_mask = '0;
    hw_set = '0;
    sw_wr = 1'h0;
    unique case (st_q.state)
      ST_IDLE: begin
        if (take) begin
          st_d.accept = 1'h1;
          st_d.state = ST_ACK;
          if (ctl_op) begin
            sw_wr = (op_class == OP_MOVE_TO_CTL);
            st_d.rvalid = (op_class == OP_MOVE_FROM_CTL);
            st_d.rdata = st_q.csr;
            st_d.host_valid = (op_class == OP_FLAG_XFER);
            st_d.host_nzcv = st_q.csr[NZCV_HI:NZCV_LO];
          end else if (trap_cond) begin
            st_d.trap = 1'h1;
          end else begin
            st_d.state = ST_RUN;
            st_d.cnt = n_ops;
            st_d.off = '0;
            st_d.units = units;
            st_d.scal_m = m_scalar;
            st_d.base_d = op_dest;
            st_d.base_n = op_src_n;
            st_d.base_m = op_src_m;
            st_d.e_double = op_double;
            st_d.e_class = op_class;
            set_mask = mask_d;
            hw_set[BIT_IN_FLUSH] = is_arith(op_class) && flush_mode && op_any_subnormal;
          end
        end
      end
      ST_RUN: begin
        st_d.e_valid = 1'h1;
        st_d.e_dest = {st_q.base_d[REG_W-1:BANK_IDX_W],
                       BANK_IDX_W'(st_q.base_d[BANK_IDX_W-1:0] + st_q.off)};
        st_d.e_n = {st_q.base_n[REG_W-1:BANK_IDX_W],
                    BANK_IDX_W'(st_q.base_n[BANK_IDX_W-1:0] + st_q.off)};
        st_d.e_m = st_q.scal_m ? st_q.base_m : {st_q.base_m[REG_W-1:BANK_IDX_W],
                   BANK_IDX_W'(st_q.base_m[BANK_IDX_W-1:0] + st_q.off)};
        st_d.e_last = (st_q.cnt == ONE_OP);
        st_d.e_wen = writes_reg(st_q.e_class);
        st_d.e_flush_in = flush_mode && is_arith(st_q.e_class);
        st_d.e_flush_res = flush_mode && is_arith(st_q.e_class);
        st_d.e_dnan = dnan_mode;
        st_d.e_keep = !dnan_mode || (st_q.e_class == OP_ABS) || (st_q.e_class == OP_NEG)
                   || (st_q.e_class == OP_COPY);
        st_d.off = BANK_IDX_W'(st_q.off + st_q.units);
        st_d.cnt = st_q.cnt - ONE_OP;
        if (st_q.cnt == ONE_OP) begin
          st_d.state = ST_IDLE;
        end
      end
      ST_ACK: begin
        st_d.state = ST_IDLE;
      end
      default: begin
        st_d.state = ST_IDLE;
      end
    endcase
    if (res_valid) begin
      hw_set[EXC_W-1:0] = hw_set[EXC_W-1:0] | res_flags;
      hw_set[BIT_UNDERFLOW] = hw_set[BIT_UNDERFLOW] | (flush_mode && res_tiny);
    end
    st_d.csr = (sw_wr ? (op_wdata & CSR_WMASK) : st_q.csr) | hw_set;
    if (cmp_valid) begin
      st_d.csr[NZCV_HI:NZCV_LO] = cmp_nzcv;
    end
    st_d.runfast = st_d.csr[BIT_FLUSH] && st_d.csr[BIT_DEF_NAN]
                && ((st_d.csr & TRAP_EN_MASK) == '0);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign op_accept = st_q.accept;
  assign trap_req = st_q.trap;
  assign ctl_rdata = st_q.rdata;
  assign ctl_rvalid = st_q.rvalid;
  assign host_nzcv = st_q.host_nzcv;
  assign host_nzcv_valid = st_q.host_valid;
  assign elem_valid = st_q.e_valid;
  assign elem_dest = st_q.e_dest;
  assign elem_src_n = st_q.e_n;
  assign elem_src_m = st_q.e_m;
  assign elem_double = st_q.e_double;
  assign elem_class = st_q.e_class;
  assign elem_last = st_q.e_last;
  assign elem_write_en = st_q.e_wen;
  assign elem_flush_inputs = st_q.e_flush_in;
  assign elem_flush_result = st_q.e_flush_res;
  assign elem_default_nan = st_q.e_dnan;
  assign elem_keep_nan_frac = st_q.e_keep;
  assign fp_status_control = st_q.csr;
  assign runfast = st_q.runfast;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_quiet2;
    !st_q.e_valid [*2];
  endsequence

  a_flush_elem_mode: assert property (
    st_q.e_valid && is_arith(st_q.e_class) |-> st_q.e_flush_in == $past(flush_mode))
    else $error("flush enable does not follow mode bit");
  a_default_nan_mode: assert property (
    st_q.e_valid |-> st_q.e_dnan == $past(dnan_mode))
    else $error("default NaN output does not follow mode bit");
  a_trap_subnorm: assert property (
    take && is_arith(op_class) && !flush_mode && op_any_subnormal |=> st_q.trap && st_q.accept)
    else $error("subnormal input did not trap");
  a_trap_nan: assert property (
    take && is_arith(op_class) && !dnan_mode && op_any_nan |=> st_q.trap)
    else $error("NaN input did not trap");
  a_trap_inexact: assert property (
    take && is_arith(op_class) && st_q.csr[BIT_INEXACT_EN] |=> st_q.trap)
    else $error("inexact enable did not trap");
  a_trap_convert: assert property (
    take && (op_class == OP_CONV_INT) && st_q.csr[BIT_INVALID_EN] && op_may_not_fit
    |=> st_q.trap)
    else $error("unsafe conversion did not trap");
  a_nonarith_free: assert property (
    take && !is_arith(op_class) |=> !st_q.trap)
    else $error("non-arithmetic operation trapped");
  a_runfast_notrap: assert property (
    take && st_q.runfast && !(op_class == OP_CONV_INT && op_may_not_fit) |=> !st_q.trap)
    else $error("trap raised in run-fast mode");
  a_flag_sticky: assert property (
    st_q.csr[BIT_UNDERFLOW] && !sw_wr |=> st_q.csr[BIT_UNDERFLOW])
    else $error("underflow flag dropped without a write");
  a_in_flush_flag: assert property (
    take && !ctl_op && !trap_cond && is_arith(op_class) && flush_mode && op_any_subnormal
    |=> st_q.csr[BIT_IN_FLUSH])
    else $error("input flush flag not set");
  a_trap_no_write: assert property (
    st_q.trap |-> s_quiet2)
    else $error("trapped operation issued elements");
  a_flag_xfer: assert property (
    st_q.host_valid |-> st_q.host_nzcv == $past(st_q.csr[NZCV_HI:NZCV_LO]))
    else $error("host flags differ from status register");
  a_last_ends: assert property (
    st_q.e_valid && st_q.e_last |=> !st_q.e_valid)
    else $error("element issued after last");

endmodule : fp_mode_trap_control

// File: fp_mode_trap_control_tb_top.sv
// Self-checking bench for the mode and trap control block.
// Assumes host_core_model issues requests; datapath inputs are driven here.
`timescale 1ns/10ps
module fp_mode_trap_control_tb_top import fp_mode_trap_pkg::*;;
  typedef struct packed {
    logic [31:0] ctl;
    op_class_t cls;
    logic [6:0] risk;
    logic trap;
    logic [1:0] fk;
  } row_t;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic res_valid = 1'b0;
  logic res_tiny = 1'b0;
  logic [4:0] res_flags = 5'h00;
  logic cmp_valid = 1'b0;
  logic [3:0] cmp_nzcv = 4'h0;
  logic [31:0] wb_clr_mask = 32'h0000_0000;
  logic op_valid, op_double, op_accept, trap_req, ctl_rvalid, host_nzcv_valid, runfast;
  logic elem_valid, elem_last, elem_flush_inputs, elem_default_nan, elem_keep_nan_frac;
  logic elem_write_en, elem_flush_result, elem_double, last_wen, last_fres, last_dbl;
  logic [4:0] elem_src_n, elem_src_m, last_n, last_m;
  op_class_t elem_class, last_cls;
  logic got_trap, got_rvalid, got_nzcv_valid, hung;
  op_class_t op_class;
  logic [14:0] op_regs;
  logic [6:0] op_risk;
  logic [4:0] elem_dest, last_dest;
  logic [31:0] op_wdata, ctl_rdata, fp_status_control, got_rdata;
  logic [3:0] host_nzcv, got_nzcv;
  logic [2:0] last_mode;
  int wait_cnt;
  int err_count = 0;
  int num_checks = 0;
  int elem_cnt = 0;
  row_t rows [16];

  always #50 core_clk = ~core_clk;

  fp_mode_trap_control u_dut (
    .core_clk, .rst_b, .op_valid, .op_class, .op_double,
    .op_dest(op_regs[14:10]), .op_src_n(op_regs[9:5]), .op_src_m(op_regs[4:0]),
    .op_wdata, .op_any_subnormal(op_risk[6]), .op_any_nan(op_risk[5]),
    .op_any_snan(op_risk[4]), .op_may_underflow(op_risk[3]), .op_may_overflow(op_risk[2]),
    .op_may_invalid(op_risk[1]), .op_may_not_fit(op_risk[0]), .res_valid, .res_tiny,
    .res_flags, .cmp_valid, .cmp_nzcv, .wb_clr_mask, .op_accept, .trap_req, .ctl_rdata,
    .ctl_rvalid, .host_nzcv, .host_nzcv_valid, .elem_valid, .elem_dest, .elem_src_n,
    .elem_src_m, .elem_double, .elem_class, .elem_last, .elem_write_en,
    .elem_flush_inputs, .elem_flush_result, .elem_default_nan, .elem_keep_nan_frac,
    .fp_status_control, .runfast
  );

  host_core_model u_host (
    .core_clk, .op_accept, .trap_req, .ctl_rdata, .ctl_rvalid, .host_nzcv, .host_nzcv_valid,
    .op_valid, .op_class, .op_double, .op_regs, .op_wdata, .op_risk, .got_trap, .got_rdata,
    .got_rvalid, .got_nzcv, .got_nzcv_valid, .wait_cnt, .hung
  );

  always @(posedge core_clk) begin
    if (elem_valid === 1'b1) begin
      elem_cnt++;
      last_mode = {elem_flush_inputs, elem_keep_nan_frac, elem_default_nan};
      last_wen = elem_write_en;
      last_fres = elem_flush_result;
      last_dbl = elem_double;
      last_cls = elem_class;
      if (elem_last === 1'b1) begin
        last_dest = elem_dest;
        last_n = elem_src_n;
        last_m = elem_src_m;
      end
    end
    if (hung === 1'b1) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk1

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk32

  task automatic print_verdict();
    if (err_count == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : do_reset

  task automatic go(input op_class_t c, input logic dbl, input logic [14:0] r,
      input logic [6:0] risk);
    elem_cnt = 0;
    u_host.issue(c, dbl, r, 32'h0000_0000, risk);
  endtask : go

  task automatic wr(input logic [31:0] v);
    u_host.issue(OP_MOVE_TO_CTL, 1'b0, 15'h0000, v, 7'h00);
  endtask : wr

  // Let elements drain, then free every register
  task automatic settle();
    repeat (12) @(posedge core_clk);
    wb_clr_mask <= 32'hFFFF_FFFF;
    @(posedge core_clk);
    wb_clr_mask <= 32'h0000_0000;
    repeat (2) @(posedge core_clk);
  endtask : settle

  task automatic vec(input logic [31:0] ctl, input logic dbl, input logic [31:0] n,
      input logic [4:0] ld, input logic [4:0] lm);
    wr(ctl);
    go(OP_ARITH, dbl, {5'h08, 5'h08, 5'h10}, 7'h00);
    settle();
    chk32(elem_cnt, n);
    chk32({27'h0, last_dest}, {27'h0, ld});
    chk32({22'h0, last_n, last_m}, {22'h0, ld, lm});
    chk1(last_dbl, dbl);
  endtask : vec

  initial begin
    rows = '{
      '{32'h0000_0000, OP_ARITH, 7'h00, 1'b0, 2'b01},
      '{32'h0000_0000, OP_ARITH, 7'h40, 1'b1, 2'b00},
      '{32'h0100_0000, OP_ARITH, 7'h40, 1'b0, 2'b11},
      '{32'h0000_0000, OP_ARITH, 7'h20, 1'b1, 2'b00},
      '{32'h0200_0000, OP_ARITH, 7'h20, 1'b0, 2'b00},
      '{32'h0000_0000, OP_ARITH, 7'h08, 1'b1, 2'b00},
      '{32'h0300_1000, OP_ARITH, 7'h00, 1'b1, 2'b00},
      '{32'h0300_0400, OP_ARITH, 7'h04, 1'b1, 2'b00},
      '{32'h0000_0400, OP_ARITH, 7'h02, 1'b0, 2'b01},
      '{32'h0300_0100, OP_ARITH, 7'h30, 1'b1, 2'b00},
      '{32'h0300_0100, OP_CONV_INT, 7'h01, 1'b1, 2'b00},
      '{32'h0300_0000, OP_ARITH, 7'h7F, 1'b0, 2'b10},
      '{32'h0300_0000, OP_ABS, 7'h60, 1'b0, 2'b01},
      '{32'h0000_0000, OP_NEG, 7'h60, 1'b0, 2'b01},
      '{32'h0200_0000, OP_COPY, 7'h20, 1'b0, 2'b01},
      '{32'h0300_0000, OP_COMPARE, 7'h40, 1'b0, 2'b00}
    };
    do_reset();
    chk32(fp_status_control, CSR_RESET);
    foreach (rows[i]) begin
      wr(rows[i].ctl);
      chk32(fp_status_control, rows[i].ctl & CSR_WMASK);
      chk1(runfast, rows[i].ctl[25:24] == 2'b11 && (rows[i].ctl & TRAP_EN_MASK) == 0);
      go(rows[i].cls, 1'b0, 15'h0000, rows[i].risk);
      settle();
      chk1(got_trap, rows[i].trap);
      chk32(elem_cnt, {31'h0, ~rows[i].trap});
      if (rows[i].trap === 1'b0) begin
        chk32({30'h0, last_mode[2:1]}, {30'h0, rows[i].fk});
        chk32({29'h0, last_wen, last_fres, last_dbl}, {29'h0, rows[i].cls != OP_COMPARE, rows[i].fk[1], 1'b0});
        chk32({28'h0, last_cls}, {28'h0, rows[i].cls});
      end
      if (rows[i].trap === 1'b0 && rows[i].cls == OP_ARITH) begin
        chk1(last_mode[0], rows[i].ctl[25]);
      end
    end
    vec(32'h0003_0000, 1'b0, 32'h4, 5'h0B, 5'h13);
    vec(32'h0037_0000, 1'b0, 32'h8, 5'h0E, 5'h16);
    vec(32'h0007_0000, 1'b1, 32'h4, 5'h0E, 5'h16);
    wr(32'h0003_0000);
    go(OP_ARITH, 1'b0, {5'h08, 5'h08, 5'h10}, 7'h00);
    repeat (8) @(posedge core_clk);
    fork
      go(OP_ARITH, 1'b0, {5'h00, 5'h09, 5'h00}, 7'h00);
      begin
        repeat (10) @(posedge core_clk);
        wb_clr_mask <= 32'hFFFF_FFFF;
        @(posedge core_clk);
        wb_clr_mask <= 32'h0000_0000;
      end
    join
    chk1(wait_cnt > 9, 1'b1);
    settle();
    wr(32'h0100_0000);
    res_valid <= 1'b1;
    res_tiny <= 1'b1;
    res_flags <= 5'h10;
    @(posedge core_clk);
    res_valid <= 1'b0;
    res_tiny <= 1'b0;
    res_flags <= 5'h00;
    go(OP_ARITH, 1'b0, 15'h0000, 7'h40);
    settle();
    go(OP_ARITH, 1'b0, 15'h0000, 7'h00);
    settle();
    go(OP_MOVE_FROM_CTL, 1'b0, 15'h0000, 7'h00);
    chk32(got_rdata, 32'h0100_0098);
    chk1(got_rvalid, 1'b1);
    wr(32'h0000_0000);
    go(OP_MOVE_FROM_CTL, 1'b0, 15'h0000, 7'h00);
    chk32(got_rdata, 32'h0000_0000);
    for (int k = 0; k < 2; k++) begin
      cmp_nzcv <= (k == 0) ? 4'hA : 4'h5;
      cmp_valid <= 1'b1;
      @(posedge core_clk);
      cmp_valid <= 1'b0;
      go(OP_FLAG_XFER, 1'b0, 15'h0000, 7'h00);
      chk32({28'h0, got_nzcv}, {28'h0, cmp_nzcv});
      chk1(got_nzcv_valid, 1'b1);
    end
    wr(32'hFFFF_FFFF);
    chk32(fp_status_control, CSR_WMASK);
    // Reset in mid-run clears the register at once
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk32(fp_status_control, CSR_RESET);
    do_reset();
    go(OP_MOVE_FROM_CTL, 1'b0, 15'h0000, 7'h00);
    chk32(got_rdata, CSR_RESET);
    print_verdict();
  end
endmodule : fp_mode_trap_control_tb_top

// File: fp_mode_trap_pkg.sv
// Constants and types for the floating-point mode and trap control block.
// Assumes a 32-register single-precision file in four banks of eight.
package fp_mode_trap_pkg;

  localparam int CSR_W = 32;
  localparam int NUM_REGS = 32;
  localparam int REG_W = 5;
  localparam int BANK_IDX_W = 3;
  localparam int MAX_SINGLE_OPS = 8;
  localparam int EXC_W = 5;

  // Field positions in fp_status_control
  localparam int NZCV_HI = 31;
  localparam int NZCV_LO = 28;
  localparam int BIT_DEF_NAN = 25;
  localparam int BIT_FLUSH = 24;
  localparam int STEP_HI = 21;
  localparam int STEP_LO = 20;
  localparam int COUNT_HI = 18;
  localparam int COUNT_LO = 16;
  localparam int BIT_INEXACT_EN = 12;
  localparam int BIT_OVFL_EN = 10;
  localparam int BIT_INVALID_EN = 8;
  localparam int BIT_IN_FLUSH = 7;
  localparam int BIT_UNDERFLOW = 3;

  localparam logic [CSR_W-1:0] CSR_RESET = 32'h0000_0000;
  // Implemented bits; all others read as zero
  localparam logic [CSR_W-1:0] CSR_WMASK = 32'hF3F7_9F9F;
  localparam logic [CSR_W-1:0] TRAP_EN_MASK = 32'h0000_9F00;

  localparam logic [3:0] ONE_OP = 4'h1;
  localparam logic [3:0] MAX_DOUBLE_OPS = 4'h4;
  localparam logic [1:0] STEP_TWO = 2'h3;
  localparam logic [1:0] SCALAR_BANK = 2'h0;
  localparam logic [2:0] UNIT_ONE = 3'h1;
  localparam logic [2:0] UNIT_TWO = 3'h2;

  typedef enum logic [3:0] {
    OP_ARITH,
    OP_CONV_INT,
    OP_ABS,
    OP_NEG,
    OP_COPY,
    OP_COMPARE,
    OP_MOVE_TO_CTL,
    OP_MOVE_FROM_CTL,
    OP_FLAG_XFER
  } op_class_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_ACK
  } seq_state_t;

endpackage : fp_mode_trap_pkg

// File: host_core_model.sv
// Host core model: presents one coprocessor request at a time, collects the answer.
// Assumes the block pulses op_accept one cycle after it takes a request.
`timescale 1ns/10ps
module host_core_model
  import fp_mode_trap_pkg::*;
(
  input wire logic core_clk,
  input wire logic op_accept,
  input wire logic trap_req,
  input wire logic [CSR_W-1:0] ctl_rdata,
  input wire logic ctl_rvalid,
  input wire logic [3:0] host_nzcv,
  input wire logic host_nzcv_valid,
  output logic op_valid,
  output op_class_t op_class,
  output logic op_double,
  output logic [14:0] op_regs,
  output logic [CSR_W-1:0] op_wdata,
  output logic [6:0] op_risk,
  output logic got_trap,
  output logic [CSR_W-1:0] got_rdata,
  output logic got_rvalid,
  output logic [3:0] got_nzcv,
  output logic got_nzcv_valid,
  output int wait_cnt,
  output logic hung
);
  initial begin
    op_valid = 1'b0;
    op_class = OP_ARITH;
    op_double = 1'b0;
    op_regs = 15'h0000;
    op_wdata = 32'h0000_0000;
    op_risk = 7'h00;
    hung = 1'b0;
  end

  task automatic issue(input op_class_t c, input logic dbl, input logic [14:0] regs,
      input logic [31:0] wd, input logic [6:0] risk);
    int n;
    n = 0;
    op_valid <= 1'b1;
    op_class <= c;
    op_double <= dbl;
    op_regs <= regs;
    op_wdata <= wd;
    op_risk <= risk;
    @(posedge core_clk);
    while (op_accept !== 1'b1 && n < 60) begin
      n++;
      @(posedge core_clk);
    end
    wait_cnt = n;
    hung = (n >= 60);
    got_trap = trap_req;
    got_rdata = ctl_rdata;
    got_rvalid = ctl_rvalid;
    got_nzcv = host_nzcv;
    got_nzcv_valid = host_nzcv_valid;
    // Released register, write data and risk fields turn to garbage, so stale values cannot pass
    op_valid <= 1'b0;
    op_regs <= ~regs;
    op_wdata <= ~wd;
    op_risk <= ~risk;
    @(posedge core_clk);
  endtask : issue
endmodule : host_core_model

// File: reg_busy_table.sv
// Busy bit per floating-point register, for issue hazard checks.
// Assumes set and clear masks come from logic on the same clock.
`timescale 1ns/10ps
module reg_busy_table #(
  parameter int NREG = 32
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [NREG-1:0] set_mask,
  input wire logic [NREG-1:0] clr_mask,
  output logic [NREG-1:0] busy_q
);

  logic [NREG-1:0] busy_d;

  // Set wins so a new writer is never lost to a completing one
  always_comb begin
    busy_d = (busy_q & ~clr_mask) | set_mask;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= '0;
    end else begin
      busy_q <= busy_d;
    end
  end

endmodule : reg_busy_table
